/* File: hdl/pcamc_pkg.sv */
// package for the counter array module mode and counter block
// ----------------------------------------------------------------
// Overview of operation
// [RQ1] wide select picks 16-bit PWM, else cycle length
// [RQ2] comparator enable turns on compare against counter
// [RQ3] rising capture enable captures on positive edge
// [RQ4] falling capture enable captures on negative edge
// [RQ5] match enable sets event flag on match
// [RQ6] toggle enable inverts pin on each match
// [RQ7] toggle plus pulse width gives frequency output
// [RQ8] pulse width enable drives PWM on pin
// [RQ9] flag irq mask gates event flag interrupt
// [RQ10] watchdog locks module 2 mode register
// [RQ11] watchdog locks both counter bytes against writes
// [RQ12] counter sixteen bits, two bytes, reset zero
// [RQ13] low byte read snapshots high byte
// [RQ14] compare low write clears comparator enable
// [RQ15] compare high write sets comparator enable
// [RQ16] cycle length selects 8 to 11 bits
// [RQ17] capture loads counter and sets flag
// [RQ18] capture inputs synchronised before edge detection
// ----------------------------------------------------------------
package pcamc_pkg;
    localparam int unsigned NUM_MOD = 3;
    localparam int unsigned WD_MOD = 2;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned ADR_W = 10;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_MODE0 = 8'hda;
    localparam logic [7:0] IDX_MODE1 = 8'hdb;
    localparam logic [7:0] IDX_MODE2 = 8'hdc;
    localparam logic [7:0] IDX_CNT_LO = 8'hf9;
    localparam logic [7:0] IDX_CNT_HI = 8'hfa;
    localparam logic [7:0] IDX_CMPL0 = 8'hfb;
    localparam logic [7:0] IDX_CMPH0 = 8'hfc;
    localparam logic [7:0] IDX_CMPL1 = 8'he9;
    localparam logic [7:0] IDX_CMPH1 = 8'hea;
    localparam logic [7:0] IDX_CMPL2 = 8'heb;
    localparam logic [7:0] IDX_CMPH2 = 8'hec;
    localparam logic [7:0] IDX_CYCLE = 8'hf7;
    localparam logic [7:0] IDX_ARRAY = 8'hd0;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hc0;
    localparam logic [7:0] IDX_IRQ_CLR = 8'hc1;
    localparam logic [7:0] IDX_IRQ_EN = 8'hc2;
    // array mode register fields
    localparam int unsigned ARR_RUN_BIT = 0;
    localparam int unsigned ARR_WD_BIT = 6;
    // cycle length field position and reset values
    localparam int unsigned CYC_LSB = 0;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] ARRAY_RST = 8'h00;
    localparam logic [2:0] IRQ_EN_RST = 3'h7;
    // module mode register layout, msb first
    typedef struct packed {
        logic wide_pwm_select;
        logic comparator_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_flag_enable;
        logic toggle_enable;
        logic pulse_width_enable;
        logic module_flag_irq_mask;
    } pcamc_mode_t;
    // one module's output pin and its enable
    typedef struct packed {
        logic level;
        logic oe;
    } pcamc_pin_t;
endpackage : pcamc_pkg

/* File: hdl/pcamc_top.sv */
// counter array: module modes, capture/compare, pwm, shared counter
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
module pcamc_top
    import pcamc_pkg::*;
(
    input wire logic clk_i, // 200 MHz system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [ADR_W-1:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic [NUM_MOD-1:0] capture_in_i, // capture input pins
    output pcamc_pin_t [NUM_MOD-1:0] module_io_pin_o, // module output pins
    output logic watchdog_expire_o, // watchdog match pulse
    output logic irq_o // level interrupt
);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdat_q;
    logic req;
    logic wr;
    logic rd;
    logic [IDX_W-1:0] idx;
    logic [7:0] wbyte;

    // single-wait-state answer; a write lands at the ack edge, a read is taken in
    // its first cycle so the snapshot and the low byte come from the same count
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & ack_q & wb_we_i & wb_sel_i[0];
    assign rd = req & ~ack_q & ~wb_we_i;
    assign idx = wb_adr_i[ADR_W-1:2];
    assign wbyte = wb_dat_i[7:0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // compare low address of module m
    function automatic logic [7:0] cmpl_idx(input int unsigned m);
        unique case (m)
            0: cmpl_idx = IDX_CMPL0;
            1: cmpl_idx = IDX_CMPL1;
            default: cmpl_idx = IDX_CMPL2;
        endcase
    endfunction

    // compare high address of module m
    function automatic logic [7:0] cmph_idx(input int unsigned m);
        unique case (m)
            0: cmph_idx = IDX_CMPH0;
            1: cmph_idx = IDX_CMPH1;
            default: cmph_idx = IDX_CMPH2;
        endcase
    endfunction

    // mode address of module m
    function automatic logic [7:0] mode_idx(input int unsigned m);
        unique case (m)
            0: mode_idx = IDX_MODE0;
            1: mode_idx = IDX_MODE1;
            default: mode_idx = IDX_MODE2;
        endcase
    endfunction

    // ack rises one cycle after the request and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ----------------------------------------------------------------
    // array control, counter and snapshot
    // ----------------------------------------------------------------
    logic [7:0] array_q;
    logic [1:0] cycle_len_q;
    logic [15:0] cnt_q;
    logic [7:0] snap_q;
    logic wd_on;
    logic run;

    assign wd_on = array_q[ARR_WD_BIT];
    assign run = array_q[ARR_RUN_BIT];

    // while the watchdog is on only its own enable bit is writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            array_q <= ARRAY_RST;
        end else if (wr && idx == IDX_ARRAY) begin
            if (wd_on) begin
                array_q[ARR_WD_BIT] <= wbyte[ARR_WD_BIT];
            end else begin
                array_q <= wbyte;
            end
        end
    end

    // shared cycle length for the narrow pwm modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cycle_len_q <= 2'h0;
        end else if (wr && idx == IDX_CYCLE) begin
            cycle_len_q <= wbyte[CYC_LSB+:2]; // RQ16
        end
    end

    // counter: software write wins over counting, locked by the watchdog
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000; // RQ12
        end else if (wr && idx == IDX_CNT_LO && !wd_on) begin
            cnt_q[7:0] <= wbyte; // RQ11
        end else if (wr && idx == IDX_CNT_HI && !wd_on) begin
            cnt_q[15:8] <= wbyte; // RQ11
        end else if (run) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // reading the low byte freezes the high byte for the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snap_q <= 8'h00;
        end else if (rd && idx == IDX_CNT_LO) begin
            snap_q <= cnt_q[15:8]; // RQ13
        end
    end

    // ----------------------------------------------------------------
    // capture/compare modules
    // ----------------------------------------------------------------
    pcamc_mode_t mode_q [NUM_MOD];
    logic [15:0] cmp_q [NUM_MOD];
    logic [NUM_MOD-1:0] flag_q;
    logic [NUM_MOD-1:0] pin_q;
    logic [2:0] irq_en_q;
    logic [NUM_MOD-1:0] match_hit;

    // narrow pwm mask from the cycle length: 8, 9, 10 or 11 bits
    logic [15:0] narrow_mask;
    always_comb begin
        unique case (cycle_len_q)
            2'h0: narrow_mask = 16'h00ff;
            2'h1: narrow_mask = 16'h01ff;
            2'h2: narrow_mask = 16'h03ff;
            2'h3: narrow_mask = 16'h07ff;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < NUM_MOD; g++) begin : g_mod
            logic [2:0] sync_q;
            logic filt_q;
            logic rise;
            logic fall;
            logic cap;
            logic locked;
            logic active;
            logic pwm_lvl;

            assign locked = (g == WD_MOD) && wd_on;
            assign active = !locked;

            // three-stage synchroniser, level follows once stages 2 and 3 agree
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync_q <= 3'h0;
                    filt_q <= 1'b0;
                end else begin
                    sync_q <= {sync_q[1:0], capture_in_i[g]}; // RQ18
                    if (sync_q[1] == sync_q[2]) begin
                        filt_q <= sync_q[2]; // RQ18
                    end
                end
            end

            // one capture event per filtered edge
            assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !filt_q;
            assign fall = (sync_q[1] == sync_q[2]) && !sync_q[2] && filt_q;
            assign cap = active && ((rise && mode_q[g].rising_capture_enable) // RQ3
                || (fall && mode_q[g].falling_capture_enable)); // RQ4

            // compare only while enabled and the counter is moving
            assign match_hit[g] = mode_q[g].comparator_enable && run
                && cnt_q == cmp_q[g]; // RQ2

            // mode register: module 2's writes ignored while it is the watchdog
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mode_q[g] <= MODE_RST;
                end else if (wr && !locked) begin
                    if (idx == mode_idx(g)) begin
                        mode_q[g] <= wbyte; // RQ10
                    end else if (idx == cmpl_idx(g)) begin
                        mode_q[g].comparator_enable <= 1'b0; // RQ14
                    end else if (idx == cmph_idx(g)) begin
                        mode_q[g].comparator_enable <= 1'b1; // RQ15
                    end
                end
            end

            // compare value: software bytes, or counter on capture
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_q[g] <= 16'h0000;
                end else if (wr && idx == cmpl_idx(g)) begin
                    cmp_q[g][7:0] <= wbyte;
                end else if (wr && idx == cmph_idx(g)) begin
                    cmp_q[g][15:8] <= wbyte;
                end else if (cap) begin
                    cmp_q[g] <= cnt_q; // RQ17
                end
            end

            // event flag: hardware set wins over a software clear
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flag_q[g] <= 1'b0;
                end else if (cap || (active && match_hit[g]
                        && mode_q[g].match_flag_enable)) begin
                    flag_q[g] <= 1'b1; // RQ5 RQ17
                end else if (wr && idx == IDX_IRQ_CLR && wbyte[g]) begin
                    flag_q[g] <= 1'b0;
                end
            end

            // pwm level: high once the counter reaches the compare value
            always_comb begin
                if (mode_q[g].wide_pwm_select) begin
                    pwm_lvl = cnt_q >= cmp_q[g]; // RQ1
                end else begin
                    pwm_lvl = (cnt_q & narrow_mask) >= (cmp_q[g] & narrow_mask); // RQ1 RQ16
                end
            end

            // output pin: frequency output, toggle, or pwm
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_q[g] <= 1'b0;
                end else if (active && mode_q[g].toggle_enable
                        && mode_q[g].pulse_width_enable) begin
                    if (mode_q[g].comparator_enable && run
                            && cnt_q[7:0] == cmp_q[g][7:0]) begin
                        pin_q[g] <= ~pin_q[g]; // RQ7
                    end
                end else if (active && mode_q[g].toggle_enable) begin
                    if (match_hit[g]) begin
                        pin_q[g] <= ~pin_q[g]; // RQ6
                    end
                end else if (active && mode_q[g].pulse_width_enable) begin
                    pin_q[g] <= pwm_lvl; // RQ8
                end
            end

            assign module_io_pin_o[g].level = pin_q[g];
            assign module_io_pin_o[g].oe = active && (mode_q[g].toggle_enable
                || mode_q[g].pulse_width_enable);
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt and watchdog
    // ----------------------------------------------------------------

    // extra enable register, reset so the mode masks alone decide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= IRQ_EN_RST;
        end else if (wr && idx == IDX_IRQ_EN) begin
            irq_en_q <= wbyte[2:0];
        end
    end

    // level interrupt while any unmasked flag is set
    always_comb begin
        irq_o = 1'b0;
        for (int m = 0; m < NUM_MOD; m++) begin
            if (flag_q[m] && mode_q[m].module_flag_irq_mask && irq_en_q[m]) begin
                irq_o = 1'b1; // RQ9
            end
        end
    end

    // module 2 as watchdog: pulse when the counter reaches its value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_expire_o <= 1'b0;
        end else begin
            watchdog_expire_o <= wd_on && run && cnt_q == cmp_q[WD_MOD]; // RQ10
        end
    end

    // ----------------------------------------------------------------
    // read data, captured in the request's first cycle
    // ----------------------------------------------------------------
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        for (int m = 0; m < NUM_MOD; m++) begin
            if (idx == mode_idx(m)) begin
                rbyte = mode_q[m];
            end else if (idx == cmpl_idx(m)) begin
                rbyte = cmp_q[m][7:0];
            end else if (idx == cmph_idx(m)) begin
                rbyte = cmp_q[m][15:8];
            end
        end
        unique case (idx)
            IDX_CNT_LO: rbyte = cnt_q[7:0];
            IDX_CNT_HI: rbyte = snap_q; // RQ13
            IDX_CYCLE: rbyte = {6'h00, cycle_len_q};
            IDX_ARRAY: rbyte = array_q;
            IDX_IRQ_STAT: rbyte = {5'h00, flag_q};
            IDX_IRQ_EN: rbyte = {5'h00, irq_en_q};
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h00000000;
        end else if (req && !ack_q) begin
            rdat_q <= {24'h000000, rbyte};
        end
    end

endmodule // pcamc_top

/* File: tb/pcamc_edge_model.sv */
// model of the external capture sources and the pin watcher
`timescale 1ns/100ps
module pcamc_edge_model
    import pcamc_pkg::*;
(
    input wire logic clk_i, // system clock
    output logic [NUM_MOD-1:0] capture_o, // capture line levels
    input pcamc_pin_t [NUM_MOD-1:0] pin_i, // module output pins
    output logic [NUM_MOD-1:0] pin_seen_o // pin levels as seen on the board
);
    initial capture_o = '0;
    // move one capture line just after an edge; lines are held for many cycles
    task automatic set_line(input int unsigned m, input logic lvl);
        @(posedge clk_i);
        capture_o[m] <= lvl;
    endtask
    // an undriven pin reads as the board pull-up
    always_ff @(posedge clk_i) begin
        for (int m = 0; m < NUM_MOD; m++) begin
            pin_seen_o[m] <= pin_i[m].oe ? pin_i[m].level : 1'b1;
        end
    end
endmodule // pcamc_edge_model

/* File: tb/pcamc_monitor.sv */
// port checker for the counter array block
`timescale 1ns/100ps
module pcamc_monitor
    import pcamc_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [ADR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic [NUM_MOD-1:0] capture_in_i, // capture lines
    input pcamc_pin_t [NUM_MOD-1:0] module_io_pin_o, // pins
    input wire logic watchdog_expire_o, // expiry
    input wire logic irq_o // interrupt
);
    logic [7:0] idx;
    logic mapped;
    logic [1:0] oe_q;
    assign idx = wb_adr_i[9:2];
    assign mapped = idx inside {IDX_MODE0, IDX_MODE1, IDX_MODE2, IDX_CNT_LO, IDX_CNT_HI,
        IDX_CMPL0, IDX_CMPH0, IDX_CMPL1, IDX_CMPH1, IDX_CMPL2, IDX_CMPH2, IDX_CYCLE,
        IDX_ARRAY, IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN};
    // expected pin enables of modules 0 and 1 from their mode writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_q <= 2'h0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == IDX_MODE0) begin
            oe_q[0] <= |wb_dat_i[2:1];
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx == IDX_MODE1) begin
            oe_q[1] <= |wb_dat_i[2:1];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o
        && !watchdog_expire_o && module_io_pin_o == '0) else $error("outputs busy in reset");
    a_wd_single: assert property (watchdog_expire_o |=> !watchdog_expire_o)
        else $error("expiry held");
    a_oe_module0: assert property (module_io_pin_o[0].oe == oe_q[0])
        else $error("pin 0 enable wrong");
    a_oe_module1: assert property (module_io_pin_o[1].oe == oe_q[1])
        else $error("pin 1 enable wrong");
    a_dat_hold: assert property (!wb_stb_i |=> $stable(wb_dat_o)) else $error("read data moved");
endmodule // pcamc_monitor

bind pcamc_top pcamc_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .capture_in_i(capture_in_i), .module_io_pin_o(module_io_pin_o),
    .watchdog_expire_o(watchdog_expire_o), .irq_o(irq_o));

/* File: tb/tb_pcamc_top.sv */
// self-checking bench for the counter array block
`timescale 1ns/100ps
module tb_pcamc_top;
    import pcamc_pkg::*;
    logic clk_i;
    logic rst_i;
    logic cyc;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic [NUM_MOD-1:0] cap;
    logic [NUM_MOD-1:0] seen;
    pcamc_pin_t [NUM_MOD-1:0] pins;
    int error_cnt = 0;
    int checks = 0;
    logic wd_exp;
    int wd_hits = 0;
    pcamc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .capture_in_i(cap), .module_io_pin_o(pins), .watchdog_expire_o(wd_exp), .irq_o(irq));
    pcamc_edge_model u_model (.clk_i(clk_i), .capture_o(cap), .pin_i(pins), .pin_seen_o(seen));
    // count watchdog expiry pulses seen on the output
    always @(posedge clk_i) begin
        if (wd_exp === 1'b1) begin
            wd_hits <= wd_hits + 1;
        end
    end
    // system clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        {cyc, we, adr, wdat} <= {1'b1, w, i, 2'b00, 24'h0, d};
        // no cycle limit here: a slave that never answers is caught by the run timeout
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        {cyc, wdat} <= {1'b0, ~wdat};
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, i, d, q);
    endtask
    task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, i, 8'h00, q);
        chk(nm, e, q);
    endtask
    task automatic ichk(input logic e);
        @(posedge clk_i);
        chk("irq", {7'h0, e}, {7'h0, irq});
    endtask
    // pin 0 as seen on the board, once the registered level has settled
    task automatic pchk(input string nm, input logic e);
        repeat (3) @(posedge clk_i);
        chk(nm, {7'h0, e}, {7'h0, seen[0]});
    endtask
    task automatic t_reset();
        rchk("mode0", IDX_MODE0, MODE_RST);
        rchk("mode1", IDX_MODE1, MODE_RST);
        rchk("mode2", IDX_MODE2, MODE_RST);
        rchk("cnt_lo", IDX_CNT_LO, 8'h00);
        rchk("cnt_hi", IDX_CNT_HI, 8'h00);
        rchk("irq_en", IDX_IRQ_EN, {5'h0, IRQ_EN_RST});
        rchk("unmapped", 8'h10, 8'h00);
    endtask
    task automatic t_counter();
        wr(IDX_CNT_LO, 8'h34);
        wr(IDX_CNT_HI, 8'h12);
        rchk("cnt_lo", IDX_CNT_LO, 8'h34);
        wr(IDX_CNT_HI, 8'h56);
        rchk("snapshot", IDX_CNT_HI, 8'h12);
        rchk("cnt_lo", IDX_CNT_LO, 8'h34);
        rchk("snapshot", IDX_CNT_HI, 8'h56);
    endtask
    task automatic t_cmp_enable();
        wr(IDX_MODE0, 8'h40);
        wr(IDX_CMPL0, 8'h10);
        rchk("cmp_low_clr", IDX_MODE0, 8'h00);
        wr(IDX_CMPH0, 8'h00);
        rchk("cmp_high_set", IDX_MODE0, 8'h40);
    endtask
    task automatic t_match_irq();
        wr(IDX_MODE0, 8'h49);
        wr(IDX_CNT_LO, 8'h00);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_ARRAY, 8'h01);
        repeat (40) @(posedge clk_i);
        wr(IDX_ARRAY, 8'h00);
        rchk("match_flag", IDX_IRQ_STAT, 8'h01);
        ichk(1'b1);
        wr(IDX_MODE0, 8'h48);
        ichk(1'b0);
        wr(IDX_MODE0, 8'h49);
        wr(IDX_IRQ_EN, 8'h06);
        ichk(1'b0);
        wr(IDX_IRQ_EN, 8'h07);
        wr(IDX_IRQ_CLR, 8'h01);
        rchk("flag_clr", IDX_IRQ_STAT, 8'h00);
        ichk(1'b0);
    endtask
    task automatic t_toggle();
        wr(IDX_CMPL1, 8'h08);
        wr(IDX_CMPH1, 8'h00);
        wr(IDX_MODE1, 8'h44);
        wr(IDX_CNT_LO, 8'h00);
        chk("pin1_idle", 8'h00, {7'h0, seen[1]});
        wr(IDX_ARRAY, 8'h01);
        repeat (40) @(posedge clk_i);
        wr(IDX_ARRAY, 8'h00);
        chk("pin1", 8'h01, {7'h0, seen[1]});
    endtask
    task automatic t_capture();
        wr(IDX_IRQ_CLR, 8'h07);
        wr(IDX_CNT_LO, 8'h5a);
        wr(IDX_MODE0, 8'h20);
        u_model.set_line(0, 1'b1);
        repeat (10) @(posedge clk_i);
        rchk("rise_cap", IDX_IRQ_STAT, 8'h01);
        rchk("cap_value", IDX_CMPL0, 8'h5a);
        wr(IDX_IRQ_CLR, 8'h01);
        u_model.set_line(0, 1'b0);
        repeat (10) @(posedge clk_i);
        rchk("fall_off", IDX_IRQ_STAT, 8'h00);
        wr(IDX_MODE0, 8'h10);
        u_model.set_line(0, 1'b1);
        repeat (10) @(posedge clk_i);
        rchk("rise_off", IDX_IRQ_STAT, 8'h00);
        u_model.set_line(0, 1'b0);
        repeat (10) @(posedge clk_i);
        rchk("fall_cap", IDX_IRQ_STAT, 8'h01);
    endtask
    // pwm widths with the counter stopped, then frequency output with it running
    task automatic t_pwm();
        wr(IDX_CMPL0, 8'h80);
        wr(IDX_CMPH0, 8'h01);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CNT_LO, 8'h90);
        wr(IDX_MODE0, 8'h02);
        pchk("pwm8", 1'b1);
        wr(IDX_CYCLE, 8'h01);
        pchk("pwm9", 1'b0);
        wr(IDX_CYCLE, 8'h00);
        wr(IDX_MODE0, 8'h82);
        pchk("pwm16", 1'b0);
        wr(IDX_CNT_HI, 8'h01);
        pchk("pwm16_hi", 1'b1);
        wr(IDX_MODE0, 8'h46);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CNT_LO, 8'h70);
        wr(IDX_ARRAY, 8'h01);
        repeat (40) @(posedge clk_i);
        wr(IDX_ARRAY, 8'h00);
        pchk("freq", 1'b0);
    endtask
    task automatic t_watchdog();
        wr(IDX_CNT_LO, 8'h11);
        wr(IDX_ARRAY, 8'h40);
        wr(IDX_CNT_LO, 8'h77);
        rchk("cnt_locked", IDX_CNT_LO, 8'h11);
        wr(IDX_MODE2, 8'h04);
        rchk("mode2_locked", IDX_MODE2, 8'h00);
        wr(IDX_ARRAY, 8'h00);
        wr(IDX_MODE2, 8'h04);
        rchk("mode2_free", IDX_MODE2, 8'h04);
        wr(IDX_CNT_LO, 8'h77);
        rchk("cnt_free", IDX_CNT_LO, 8'h77);
        wr(IDX_CMPL2, 8'h30);
        wr(IDX_CMPH2, 8'h00);
        wr(IDX_CNT_LO, 8'h00);
        wr(IDX_ARRAY, 8'h41);
        repeat (80) @(posedge clk_i);
        wr(IDX_ARRAY, 8'h00);
        wr(IDX_ARRAY, 8'h00);
        chk("wd_expire", 8'h01, wd_hits[7:0]);
    endtask
    // reset, then the scenarios in turn
    initial begin
        {rst_i, cyc, we, adr, wdat} = {1'b1, 1'b0, 1'b0, 10'h0, 32'h0};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_counter();
        t_cmp_enable();
        t_match_irq();
        t_toggle();
        t_capture();
        t_pwm();
        t_watchdog();
        close_out();
    end
    // watchdog against a hung bus or scenario
    initial begin
        #50000;
        error_cnt++;
        close_out();
    end
endmodule // tb_pcamc_top
